// ---- hdl/wake_edge_detect.sv ----
`timescale 1ns/10ps
// synchronises the wake pins and flags the selected edge
module wake_edge_detect (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [5:0] pin_i,
    input wire logic [5:0] edge_rise_i,
    output logic [5:0] edge_hit_o
);
    logic [5:0] sync_a; // first stage, read only by sync_b
    logic [5:0] sync_b; // second stage
    logic [5:0] prev; // delayed copy for edge detection

    // two-flop synchroniser plus history
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
            prev <= 6'h00;
        end else if (ce_i) begin
            sync_a <= pin_i;
            sync_b <= sync_a;
            prev <= sync_b;
        end
    end

    // per-pin edge choice: 1 selects rising, 0 falling
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            edge_hit_o[i] = edge_rise_i[i] ? (sync_b[i] & ~prev[i]) : (~sync_b[i] & prev[i]); // RULE_13
        end
    end
endmodule

// ---- hdl/wake_reset_pkg.sv ----
package wake_reset_pkg;
    // register map (byte addresses on the plain register port)
    localparam logic [3:0] addr_wake_flag = 4'h0;
    localparam logic [3:0] addr_wake_cfg = 4'h1;
    localparam logic [3:0] addr_edge_sel = 4'h2;
    localparam logic [3:0] addr_irq_status = 4'h3;
    localparam logic [3:0] addr_irq_mask = 4'h4;
    localparam logic [3:0] addr_seq_status = 4'h5;
    localparam logic [3:0] addr_first_done = 4'h6;
    // field layout of the wakeup flag register
    localparam int flag_count = 6;
    localparam logic [1:0] flag_reserved_val = 2'h3;
    localparam logic [5:0] flag_reset_val = 6'h00;
    localparam logic [5:0] cfg_reset_val = 6'h00;
    localparam logic [5:0] edge_reset_val = 6'h00;
    // interrupt status bits
    localparam int irq_bit_wake = 0;
    localparam int irq_bit_reset_done = 1;
    localparam logic [1:0] irq_mask_reset_val = 2'h0;
    // reset vector location and core-facing constants
    localparam logic [15:0] reset_vector_addr = 16'h0000;
    localparam logic [15:0] pc_reset_val = 16'h0000;
    // least reset low time: 10 system clock cycles
    localparam int reset_min_cycles = 10;
    localparam logic [3:0] reset_cnt_max = 4'(reset_min_cycles);
    // sequencer states
    typedef enum logic [2:0] {
        st_reset,
        st_set_mask,
        st_vec_fetch,
        st_vec_wait,
        st_first_instr,
        st_run
    } seq_state_e;
endpackage

// ---- hdl/wakeup_flags_reset_entry.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// RULE_01 - selected pin edge sets its flag
// RULE_02 - only a written 0 clears a flag
// RULE_03 - bits 7 and 6 read as 1
// RULE_04 - flags are 0 after reset
// RULE_05 - reset pin low halts everything immediately (here on the third clock edge, after the two-flop pin synchroniser)
// RULE_06 - reset initialises all block registers
// RULE_07 - source holds reset low 10 cycles
// RULE_08 - source holds reset until clock stable
// RULE_09 - reset release starts exception sequence
// RULE_10 - first step sets interrupt mask bit
// RULE_11 - fetch vector at 0000, load pc
// RULE_12 - refuse all interrupts until first instruction
// RULE_13 - each pin has own edge select
// RULE_14 - set beats clear in same cycle
module wakeup_flags_reset_entry (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic chip_clear_in_n_i,
    input wire logic [5:0] wake_pin_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic irq_o,
    output logic core_halt_o,
    output logic cond_code_mask_o,
    output logic vec_rd_o,
    output logic [15:0] vec_addr_o,
    input wire logic [15:0] vec_data_i,
    output logic [15:0] pc_load_val_o,
    output logic pc_load_o,
    output logic intr_block_o,
    output logic wake_req_o
);
    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic clr_sync_a; // first synchroniser stage of the reset pin
    logic clr_sync_b; // synchronised reset pin, high means running
    logic in_clear; // internal clear: external reset or pin low
    logic [5:0] wake_req_flag; // wake_req_flag_5..0
    logic [5:0] wake_cfg; // 1 = pin used as interrupt input
    logic [5:0] edge_rise; // 1 = rising edge, 0 = falling
    logic [5:0] edge_hit; // edge events from the detector
    logic [1:0] irq_status; // sticky events
    logic [1:0] irq_mask; // 1 = enable event onto irq_o
    logic [3:0] low_cnt; // counts reset-low cycles, saturating
    logic low_long; // reset held long enough
    logic first_done_wr; // core reports first instruction executed
    wake_reset_pkg::seq_state_e state;
    wake_reset_pkg::seq_state_e next_state;
    logic [5:0] next_flag;
    logic [7:0] next_rdata;
    logic flag_wr; // write strobe aimed at the flag register
    logic status_rd; // read strobe aimed at the status register
    logic [5:0] wake_event; // edges on pins set up as interrupt inputs

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    // one strobe at one register offset
    function automatic logic reg_hit(input logic strobe, input logic [3:0] addr, input logic [3:0] target);
        return strobe && (addr == target);
    endfunction

    // an edge counts only on a pin configured as interrupt input
    function automatic logic [5:0] live_edges(input logic [5:0] hits, input logic [5:0] cfg);
        return hits & cfg;
    endfunction

    // the reset pin is asynchronous to clk, so it passes two flops first
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            clr_sync_a <= 1'b0;
            clr_sync_b <= 1'b0;
        end else begin
            clr_sync_a <= chip_clear_in_n_i;
            clr_sync_b <= clr_sync_a;
        end
    end

    // pin low acts regardless of clock enable, so halting does not wait for ce_i
    assign in_clear = rst_i | ~clr_sync_b; // RULE_05

    ////////////////////////////////////////////////////////////////////////////
    // edge detection
    wake_edge_detect u_edge (
        .clk_sys_i(clk_sys_i),
        .rst_i(in_clear),
        .ce_i(ce_i),
        .pin_i(wake_pin_i),
        .edge_rise_i(edge_rise),
        .edge_hit_o(edge_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // strobe decode, shared by the processes below
    assign flag_wr = reg_hit(reg_wr_i, reg_addr_i, wake_reset_pkg::addr_wake_flag);
    assign status_rd = reg_hit(reg_rd_i, reg_addr_i, wake_reset_pkg::addr_irq_status);
    assign first_done_wr = reg_hit(reg_wr_i, reg_addr_i, wake_reset_pkg::addr_first_done);
    assign wake_event = live_edges(edge_hit, wake_cfg); // RULE_01

    ////////////////////////////////////////////////////////////////////////////
    // reset low time counter
    // counts while low; a too-short pulse still resets, but no new
    // sequence starts unless the minimum was reached
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            low_cnt <= wake_reset_pkg::reset_cnt_max;
        end else if (!clr_sync_b) begin
            if (low_cnt != wake_reset_pkg::reset_cnt_max) begin
                low_cnt <= low_cnt + 4'h1;
            end
        end else if (state != wake_reset_pkg::st_reset || !low_long) begin
            low_cnt <= 4'h0; // rearm once running; a pulse below the minimum is forgotten
        end
    end
    assign low_long = (low_cnt == wake_reset_pkg::reset_cnt_max); // RULE_07

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk_sys_i) begin
        if (in_clear) begin
            wake_cfg <= wake_reset_pkg::cfg_reset_val; // RULE_06
            edge_rise <= wake_reset_pkg::edge_reset_val; // RULE_06
            irq_mask <= wake_reset_pkg::irq_mask_reset_val;
        end else if (ce_i && reg_wr_i) begin
            case (reg_addr_i)
                wake_reset_pkg::addr_wake_cfg: wake_cfg <= reg_wdata_i[5:0];
                wake_reset_pkg::addr_edge_sel: edge_rise <= reg_wdata_i[5:0]; // RULE_13
                wake_reset_pkg::addr_irq_mask: irq_mask <= reg_wdata_i[1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wakeup request flags
    // writing 0 clears, writing 1 leaves the bit; a new edge wins over clear
    always_comb begin
        next_flag = wake_req_flag;
        if (flag_wr) begin
            next_flag = wake_req_flag & reg_wdata_i[5:0]; // RULE_02
        end
        next_flag = next_flag | wake_event; // RULE_01 RULE_14
    end

    always_ff @(posedge clk_sys_i) begin
        if (in_clear) begin
            wake_req_flag <= wake_reset_pkg::flag_reset_val; // RULE_04
        end else if (ce_i) begin
            wake_req_flag <= next_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset exception sequencer
    always_comb begin
        next_state = state;
        case (state)
            wake_reset_pkg::st_reset: begin
                if (low_long) begin
                    next_state = wake_reset_pkg::st_set_mask; // RULE_09
                end
            end
            wake_reset_pkg::st_set_mask: next_state = wake_reset_pkg::st_vec_fetch; // RULE_10
            wake_reset_pkg::st_vec_fetch: next_state = wake_reset_pkg::st_vec_wait;
            wake_reset_pkg::st_vec_wait: next_state = wake_reset_pkg::st_first_instr; // RULE_11
            wake_reset_pkg::st_first_instr: begin
                if (first_done_wr) begin
                    next_state = wake_reset_pkg::st_run;
                end
            end
            wake_reset_pkg::st_run: next_state = wake_reset_pkg::st_run;
            default: next_state = wake_reset_pkg::st_reset;
        endcase
    end

    // in reset the sequencer sits in st_reset; it leaves only after release
    always_ff @(posedge clk_sys_i) begin
        if (in_clear) begin
            state <= wake_reset_pkg::st_reset; // RULE_05
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core-facing outputs, all straight from flops, one process per concern

    // halt: raised by any clear, dropped together with the pc load pulse
    always_ff @(posedge clk_sys_i) begin
        if (in_clear) begin
            core_halt_o <= 1'b1; // RULE_05
        end else if (ce_i) begin
            if (state == wake_reset_pkg::st_vec_wait) begin
                core_halt_o <= 1'b0; // core starts fetching at the vector
            end
        end
    end

    // interrupt mask bit: set as the first step, handed back once running
    always_ff @(posedge clk_sys_i) begin
        if (in_clear) begin
            cond_code_mask_o <= 1'b0; // RULE_06
        end else if (ce_i) begin
            if (state == wake_reset_pkg::st_set_mask) begin
                cond_code_mask_o <= 1'b1; // RULE_10
            end else if (state == wake_reset_pkg::st_run) begin
                cond_code_mask_o <= 1'b0; // execution owns the mask from here
            end
        end
    end

    // vector read request: one pulse, issued as the fetch state is entered
    always_ff @(posedge clk_sys_i) begin
        if (in_clear) begin
            vec_rd_o <= 1'b0;
            vec_addr_o <= wake_reset_pkg::reset_vector_addr;
        end else if (ce_i) begin
            vec_rd_o <= (next_state == wake_reset_pkg::st_vec_fetch);
            vec_addr_o <= wake_reset_pkg::reset_vector_addr; // RULE_11
        end
    end

    // pc load: the word is taken in the cycle after the request, while it stands
    always_ff @(posedge clk_sys_i) begin
        if (in_clear) begin
            pc_load_o <= 1'b0;
            pc_load_val_o <= wake_reset_pkg::pc_reset_val;
        end else if (ce_i) begin
            pc_load_o <= 1'b0; // one-cycle pulse
            if (state == wake_reset_pkg::st_vec_wait) begin
                pc_load_val_o <= vec_data_i; // RULE_11
                pc_load_o <= 1'b1;
            end
        end
    end

    // interrupt gate: closed from reset until the first instruction has run
    always_ff @(posedge clk_sys_i) begin
        if (in_clear) begin
            intr_block_o <= 1'b1; // RULE_12
        end else if (ce_i) begin
            intr_block_o <= (next_state != wake_reset_pkg::st_run); // RULE_12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status: sticky, cleared by reading it; set beats clear
    always_ff @(posedge clk_sys_i) begin
        if (in_clear) begin
            irq_status <= 2'h0;
        end else if (ce_i) begin
            irq_status <= status_rd ? 2'h0 : irq_status;
            if (|wake_event) begin
                irq_status[wake_reset_pkg::irq_bit_wake] <= 1'b1;
            end
            if (state == wake_reset_pkg::st_first_instr && first_done_wr) begin
                irq_status[wake_reset_pkg::irq_bit_reset_done] <= 1'b1;
            end
        end
    end

    // interrupt output held off until the first instruction has run
    always_ff @(posedge clk_sys_i) begin
        if (in_clear) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |(irq_status & irq_mask) && state == wake_reset_pkg::st_run; // RULE_12
        end
    end

    // wake request level: any flag set, behind the same gate as the interrupt
    always_ff @(posedge clk_sys_i) begin
        if (in_clear) begin
            wake_req_o <= 1'b0;
        end else if (ce_i) begin
            wake_req_o <= |next_flag && state == wake_reset_pkg::st_run; // RULE_12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path: data one cycle after the strobe, unmapped reads zero
    always_comb begin
        case (reg_addr_i)
            wake_reset_pkg::addr_wake_flag: next_rdata = {wake_reset_pkg::flag_reserved_val, wake_req_flag}; // RULE_03
            wake_reset_pkg::addr_wake_cfg: next_rdata = {2'h0, wake_cfg};
            wake_reset_pkg::addr_edge_sel: next_rdata = {2'h0, edge_rise};
            wake_reset_pkg::addr_irq_status: next_rdata = {6'h00, irq_status};
            wake_reset_pkg::addr_irq_mask: next_rdata = {6'h00, irq_mask};
            wake_reset_pkg::addr_seq_status: next_rdata = {4'h0, intr_block_o, 3'(state)};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (in_clear) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
        end
    end
endmodule

// ---- verif/wake_core_model.sv ----
`timescale 1ns/10ps
// core side: answers the vector read one cycle after the request
module wake_core_model #(
    parameter logic [15:0] vector = 16'h0c40 // arbitrary start address
) (
    input wire logic clk_sys_i,
    input wire logic vec_rd_i,
    output logic [15:0] vec_data_o
);
    // the word stands only in the cycle after the request; otherwise its inverse
    always_ff @(posedge clk_sys_i) begin
        if (vec_rd_i) begin
            vec_data_o <= vector;
        end else begin
            vec_data_o <= ~vector;
        end
    end
endmodule

// ---- verif/wake_entry_checker.sv ----
`timescale 1ns/10ps
// watches the top ports only
module wake_entry_checker (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic chip_clear_in_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic irq_o,
    input wire logic core_halt_o,
    input wire logic cond_code_mask_o,
    input wire logic vec_rd_o,
    input wire logic [15:0] vec_addr_o,
    input wire logic pc_load_o,
    input wire logic intr_block_o,
    input wire logic wake_req_o
);
    logic [3:0] pin_hist; // reads are trusted only once the pin has been high a while
    wire logic quiet = &pin_hist && chip_clear_in_n_i && ce_i;
    wire logic flag_wr = reg_wr_i && reg_addr_i == wake_reset_pkg::addr_wake_flag;
    always_ff @(posedge clk_sys_i) begin
        pin_hist <= {pin_hist[2:0], chip_clear_in_n_i};
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    reserved_bits_a: assert property (quiet && reg_rd_i && reg_addr_i == wake_reset_pkg::addr_wake_flag
        |=> reg_rdata_o[7:6] == wake_reset_pkg::flag_reserved_val) else $error("reserved bits not 1");
    reset_state_a: assert property ($fell(rst_i) |-> core_halt_o && intr_block_o && !irq_o && !pc_load_o)
        else $error("outputs not at reset values");
    pin_halt_a: assert property (!chip_clear_in_n_i [*3] |=> core_halt_o && intr_block_o)
        else $error("pin reset did not halt");
    mask_first_a: assert property (vec_rd_o |-> cond_code_mask_o) else $error("mask not set before fetch");
    vec_addr_a: assert property (vec_rd_o |-> vec_addr_o == wake_reset_pkg::reset_vector_addr)
        else $error("vector address wrong");
    vec_to_pc_a: assert property (vec_rd_o |-> ##[1:3] pc_load_o) else $error("pc not loaded");
    block_at_load_a: assert property (pc_load_o |-> intr_block_o) else $error("interrupts open at load");
    irq_blocked_a: assert property (intr_block_o |-> !irq_o && !wake_req_o) else $error("irq while blocked");
    flag_clear_a: assert property (quiet && $fell(wake_req_o)
        |-> $past(flag_wr, 1) || $past(flag_wr, 2) || $past(flag_wr, 3)) else $error("flag cleared without write");
endmodule
bind wakeup_flags_reset_entry wake_entry_checker wake_entry_checker_i (.clk_sys_i, .rst_i, .ce_i, .chip_clear_in_n_i,
    .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .core_halt_o, .cond_code_mask_o, .vec_rd_o,
    .vec_addr_o, .pc_load_o, .intr_block_o, .wake_req_o);

// ---- verif/wakeup_flags_reset_entry_bench.sv ----
`timescale 1ns/10ps
module wakeup_flags_reset_entry_bench;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic chip_clear_in_n_i = 1'b0; // external clear pin held low at power-up
    logic [5:0] wake_pin_i = 6'h00;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic irq_o, core_halt_o, cond_code_mask_o, vec_rd_o, pc_load_o, intr_block_o, wake_req_o;
    logic [15:0] vec_addr_o, vec_data_i, pc_load_val_o;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    wakeup_flags_reset_entry wakeup_flags_reset_entry_i (.clk_sys_i, .rst_i, .ce_i, .chip_clear_in_n_i, .wake_pin_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .core_halt_o, .cond_code_mask_o,
        .vec_rd_o, .vec_addr_o, .vec_data_i, .pc_load_val_o, .pc_load_o, .intr_block_o, .wake_req_o);
    wake_core_model #(.vector(16'h0c40)) wake_core_model_i (.clk_sys_i, .vec_rd_i(vec_rd_o), .vec_data_o(vec_data_i));
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // hang guard: the whole sequence needs just over a hundred cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(what, {8'h00, reg_rdata_o}, {8'h00, exp});
    endtask
    task automatic pins_to(input logic [5:0] v);
        @(posedge clk_sys_i);
        wake_pin_i <= v;
        repeat (6) @(posedge clk_sys_i); // sync plus edge stage
        #1;
    endtask
    // bounded wait for the one-cycle pc load pulse
    task automatic wait_load;
        int i;
        for (i = 0; i < 30 && pc_load_o !== 1'b1; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk("pc load", {15'h0000, pc_load_o}, 16'h0001);
        chk("pc value", pc_load_val_o, 16'h0c40);
        chk("mask at load", {15'h0000, cond_code_mask_o}, 16'h0001);
        chk("core released", {15'h0000, core_halt_o}, 16'h0000);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chip_clear_in_n_i <= 1'b1;
        wait_load();
        rd(wake_reset_pkg::addr_wake_flag, 8'hc0, "flags after reset");
        rd(wake_reset_pkg::addr_seq_status, 8'h0c, "blocked before first");
        wr(wake_reset_pkg::addr_irq_mask, 8'h01);
        wr(wake_reset_pkg::addr_wake_cfg, 8'h3f);
        wr(wake_reset_pkg::addr_edge_sel, 8'h2a);
        pins_to(6'h3f);
        chk("irq while blocked", {15'h0000, irq_o}, 16'h0000);
        rd(wake_reset_pkg::addr_wake_flag, 8'hea, "rising edges");
        wr(wake_reset_pkg::addr_first_done, 8'h00);
        rd(wake_reset_pkg::addr_seq_status, 8'h05, "run state");
        chk("irq in run", {15'h0000, irq_o}, 16'h0001);
        rd(wake_reset_pkg::addr_irq_status, 8'h03, "status read");
        @(posedge clk_sys_i);
        #1;
        chk("irq after read", {15'h0000, irq_o}, 16'h0000);
        pins_to(6'h00);
        rd(wake_reset_pkg::addr_wake_flag, 8'hff, "falling edges");
        wr(wake_reset_pkg::addr_wake_flag, 8'h3c);
        rd(wake_reset_pkg::addr_wake_flag, 8'hfc, "zero clears");
        chk("wake req", {15'h0000, wake_req_o}, 16'h0001);
        @(posedge clk_sys_i);
        wake_pin_i <= 6'h20; // pin 5 rises so that its edge lands with the clear below
        @(posedge clk_sys_i);
        wr(wake_reset_pkg::addr_wake_flag, 8'h00);
        rd(wake_reset_pkg::addr_wake_flag, 8'he0, "set beats clear");
        @(posedge clk_sys_i);
        ce_i <= 1'b0; // frozen: the write below must be ignored
        wr(wake_reset_pkg::addr_wake_flag, 8'h00);
        ce_i <= 1'b1;
        rd(wake_reset_pkg::addr_wake_flag, 8'he0, "write while frozen");
        wr(wake_reset_pkg::addr_wake_flag, 8'h00);
        rd(wake_reset_pkg::addr_wake_flag, 8'hc0, "all cleared");
        chk("wake req idle", {15'h0000, wake_req_o}, 16'h0000);
        @(posedge clk_sys_i);
        chip_clear_in_n_i <= 1'b0; // pulse shorter than the minimum
        repeat (5) @(posedge clk_sys_i);
        chip_clear_in_n_i <= 1'b1;
        repeat (12) @(posedge clk_sys_i);
        #1;
        chk("short pulse", {14'h0000, core_halt_o, cond_code_mask_o}, 16'h0002);
        @(posedge clk_sys_i);
        chip_clear_in_n_i <= 1'b0;
        repeat (12) @(posedge clk_sys_i);
        chk("halted", {14'h0000, core_halt_o, intr_block_o}, 16'h0003);
        chip_clear_in_n_i <= 1'b1;
        wait_load();
        rd(wake_reset_pkg::addr_wake_flag, 8'hc0, "flags after pin reset");
        rd(wake_reset_pkg::addr_edge_sel, 8'h00, "edge select reset");
        rd(4'hf, 8'h00, "unmapped");
        wrap_up();
    end
endmodule
